/* File: rtl/gated_timer_consts.vh */
// Constants for the gated sixteen bit timer: offsets, fields, resets.
`ifndef GATED_TIMER_CONSTS_VH
`define GATED_TIMER_CONSTS_VH

// Register byte addresses on the APB.
`define OFS_CONTROL     12'h000
`define OFS_COUNT_LOW   12'h004
`define OFS_COUNT_HIGH  12'h008
`define OFS_IRQ         12'h00C
`define OFS_CC_LOW      12'h010
`define OFS_CC_HIGH     12'h014
`define OFS_STATUS      12'h018

// Control register fields.
`define CTL_TIMER_ON    0
`define CTL_SOURCE      1
`define CTL_SYNC_BYP    2
`define CTL_LP_OSC_EN   3
`define CTL_PRE_LO      4
`define CTL_PRE_HI      5
`define CTL_GATE_EN     6
`define CTL_GATE_POL    7
`define CTL_FAST_INT    8
`define CTL_GATE_SRC    9
`define CTL_CAPTURE     10
`define CTL_COMPARE     11
`define CTL_WIDTH       12
`define CTL_RESET       12'h000

// Interrupt register fields.
`define IRQ_FLAG        0
`define IRQ_ENABLE      1
`define IRQ_PERIPH      2
`define IRQ_GLOBAL      3
`define IRQ_CMP_FLAG    4

// Status register fields.
`define ST_DIR4         0
`define ST_DIR5         1
`define ST_PORT4        2
`define ST_PORT5        3
`define ST_TIMEBASE     4
`define ST_ARMED        5

// Counter limits and the instruction clock phase.
`define COUNT_MAX       16'hFFFF
`define COUNT_ZERO      16'h0000
`define PHASE_LAST      2'h3
`define PRE_ZERO        3'h0
`define SYNC_WIDTH      5

`endif

/* File: rtl/pin_sync.v */
// Two flip-flop synchroniser for the asynchronous pins of the timer.
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 5
) (
    input  wire             ref_clk,
    input  wire             nrst,
    input  wire [WIDTH-1:0] pins_in,
    output wire [WIDTH-1:0] pins_out
);

    // ======================================================================
    // Synchroniser stages
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_sync
            reg first_q;
            reg second_q;
            always @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    first_q  <= 1'b0;
                    second_q <= 1'b0;
                end
                else
                begin
                    first_q  <= pins_in[i];
                    second_q <= first_q;
                end
            end
            assign pins_out[i] = second_q;
        end
    endgenerate

endmodule // pin_sync

/* File: rtl/gated_sixteen_bit_timer.v */
// Sixteen bit gated timer and counter with an APB register slave.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "gated_timer_consts.vh"

// Overview of operation
// R1: Sixteen bit counter, two separately reached bytes.
// R2: Byte writes replace the live counter byte.
// R3: Select instruction clock, system clock or pin.
// R4: External mode counts rising pin edges.
// R5: First rising edge needs prior falling edge.
// R6: Prescaler divides by one, two, four, eight.
// R7: Prescaler hidden; cleared by any count write.
// R8: Oscillator enable starts crystal, runs in sleep.
// R9: Crystal clocks counter only when allowed.
// R10: Oscillator forces direction bits one, port zero.
// R11: Software waits oscillator start-up before enabling.
// R12: Bypass mode counts in sleep, may wake.
// R13: Mode switches may lose or add one.
// R14: No time base in asynchronous or fast mode.
// R15: Byte reads always return a valid value.
// R16: Software stops counter before asynchronous writes.
// R17: Gate from pin or comparator when enabled.
// R18: Gate polarity inverts either gate source.
// R19: Rollover from all ones sets the flag.
// R20: Interrupt needs three enables; software clears flag.
// R21: Overflow in sleep wakes core when enabled.
// R22: Capture copies counter into capture pair.
// R23: Compare match raises an event.
// R24: Polarity one counts high, zero counts low.
// R25: Timer on enables; gate ignored while off.
// R26: Prescale codes map to one, two, four, eight.
// R27: Bypass ignored with the internal source.
// R28: Synchronised mode resynchronises pin before edges.
module gated_sixteen_bit_timer (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire        ext_count_input,
    input  wire        lp_osc_clk,
    input  wire        gate_pin,
    input  wire        comparator_two_out,
    input  wire        capture_event,
    input  wire        sleep_mode,
    input  wire        osc_use_allowed,
    input  wire        dir_bit_4_in,
    input  wire        dir_bit_5_in,
    input  wire        port_bit_4_in,
    input  wire        port_bit_5_in,
    output wire        lp_osc_run,
    output wire        dir_bit_4,
    output wire        dir_bit_5,
    output wire        port_bit_4,
    output wire        port_bit_5,
    output wire        rollover_irq,
    output reg         wake_req,
    output reg         compare_event,
    output wire        timebase_valid
);

    // ======================================================================
    // Declarations
    reg  [`CTL_WIDTH-1:0] ctrl_q;
    reg  [15:0]           count_q;
    reg  [15:0]           count_d;
    reg  [15:0]           cc_q;
    reg  [2:0]            pre_q;
    reg  [1:0]            phase_q;
    reg                   rollover_flag_q;
    reg                   compare_flag_q;
    reg                   rollover_irq_enable_q;
    reg                   peripheral_irq_enable_q;
    reg                   global_irq_enable_q;
    reg                   armed_q;
    reg                   ext_prev_q;
    reg                   ext_resync_q;
    reg                   cap_prev_q;
    wire [4:0]            pins_raw;
    wire [4:0]            pins_s;
    wire                  wr_en;
    wire                  rd_en;
    wire                  timer_on;
    wire                  source_select;
    wire                  sync_bypass;
    wire                  low_power_osc_enable;
    wire [1:0]            prescale_select;
    wire                  gate_enable;
    wire                  gate_polarity;
    wire                  fast_internal_select;
    wire                  gate_source;
    wire                  ext_src;
    wire                  ext_level;
    wire                  ext_rise;
    wire                  ext_fall;
    wire                  int_tick;
    wire                  tick;
    wire                  gate_level;
    wire                  gate_ok;
    wire                  run;
    wire [2:0]            pre_mask;
    wire                  inc;
    wire                  roll;
    wire                  wr_low;
    wire                  wr_high;
    wire                  wr_irq;
    wire                  cap_rise;

    // ======================================================================
    // Control fields
    assign timer_on             = ctrl_q[`CTL_TIMER_ON];
    assign source_select        = ctrl_q[`CTL_SOURCE];
    assign sync_bypass          = ctrl_q[`CTL_SYNC_BYP];
    assign low_power_osc_enable = ctrl_q[`CTL_LP_OSC_EN];
    assign prescale_select      = ctrl_q[`CTL_PRE_HI:`CTL_PRE_LO];
    assign gate_enable          = ctrl_q[`CTL_GATE_EN];
    assign gate_polarity        = ctrl_q[`CTL_GATE_POL];
    assign fast_internal_select = ctrl_q[`CTL_FAST_INT];
    assign gate_source          = ctrl_q[`CTL_GATE_SRC];

    // ======================================================================
    // Pin synchronisation
    assign pins_raw = {capture_event, comparator_two_out, gate_pin,
                       lp_osc_clk, ext_count_input};

    pin_sync #(
        .WIDTH    (`SYNC_WIDTH)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .pins_in  (pins_raw),
        .pins_out (pins_s)
    );

    // ======================================================================
    // Oscillator and port overrides
    assign lp_osc_run = low_power_osc_enable; // [R8]
    assign dir_bit_4  = low_power_osc_enable | dir_bit_4_in; // [R10]
    assign dir_bit_5  = low_power_osc_enable | dir_bit_5_in; // [R10]
    assign port_bit_4 = ~low_power_osc_enable & port_bit_4_in; // [R10]
    assign port_bit_5 = ~low_power_osc_enable & port_bit_5_in; // [R10]

    // ======================================================================
    // Clock source selection
    // The crystal replaces the pin only when the system clock permits.
    assign ext_level = (low_power_osc_enable & osc_use_allowed) ?
                       pins_s[1] : pins_s[0]; // [R9]
    assign ext_src   = source_select; // [R3]

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_q      <= 2'h0;
            ext_resync_q <= 1'b0;
            ext_prev_q   <= 1'b0;
            armed_q      <= 1'b0;
        end
        else
        begin
            phase_q      <= phase_q + 2'h1;
            ext_resync_q <= ext_level; // [R28]
            ext_prev_q   <= (ext_src & ~sync_bypass) ? ext_resync_q
                                                     : ext_level;
            if (!ext_src || !timer_on)
                armed_q <= 1'b0; // [R5]
            else if (ext_fall)
                armed_q <= 1'b1; // [R5]
        end
    end

    // Bypass shortens the path by one stage, so a mode switch may skip
    // or repeat one edge. [R13]
    assign ext_rise = (sync_bypass ? ext_level : ext_resync_q)
                      & ~ext_prev_q; // [R4] [R27]
    assign ext_fall = ~(sync_bypass ? ext_level : ext_resync_q)
                      & ext_prev_q;
    assign int_tick = fast_internal_select ? 1'b1
                                           : (phase_q == `PHASE_LAST);
    assign tick     = ext_src ? (ext_rise & armed_q) : int_tick; // [R3] [R5]

    // ======================================================================
    // Gate and run control
    assign gate_level = gate_source ? pins_s[3] : pins_s[2]; // [R17]
    assign gate_ok    = ~gate_enable
                        | ~(gate_level ^ gate_polarity); // [R18] [R24]
    // Only the asynchronous external counter keeps running in sleep.
    assign run = timer_on & gate_ok
                 & (~sleep_mode | (ext_src & sync_bypass)); // [R12] [R25]

    // ======================================================================
    // Prescaler
    assign pre_mask = (prescale_select == 2'b00) ? 3'b000 :
                      (prescale_select == 2'b01) ? 3'b001 :
                      (prescale_select == 2'b10) ? 3'b011 :
                                                   3'b111; // [R26]
    assign inc  = tick & run & ((pre_q & pre_mask) == pre_mask); // [R6]
    assign roll = inc & (count_q == `COUNT_MAX); // [R19]

    // ======================================================================
    // APB decode
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign wr_low  = wr_en & (paddr == `OFS_COUNT_LOW);
    assign wr_high = wr_en & (paddr == `OFS_COUNT_HIGH);
    assign wr_irq  = wr_en & (paddr == `OFS_IRQ);

    // ======================================================================
    // Counter and prescaler update
    always @*
    begin
        count_d = count_q;
        if (inc)
            count_d = count_q + 16'h0001; // [R1]
        if (wr_low)
            count_d = {count_d[15:8], pwdata[7:0]}; // [R2] [R16]
        if (wr_high)
            count_d = {pwdata[7:0], count_d[7:0]}; // [R2] [R16]
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q <= `COUNT_ZERO;
            pre_q   <= `PRE_ZERO;
        end
        else
        begin
            count_q <= count_d;
            if (wr_low || wr_high)
                pre_q <= `PRE_ZERO; // [R7]
            else if (inc)
                pre_q <= `PRE_ZERO;
            else if (tick && run)
                pre_q <= pre_q + 3'h1; // [R6]
        end
    end

    // ======================================================================
    // Control and interrupt registers
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q                  <= `CTL_RESET;
            rollover_flag_q         <= 1'b0;
            compare_flag_q          <= 1'b0;
            rollover_irq_enable_q   <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
            global_irq_enable_q     <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == `OFS_CONTROL)
                ctrl_q <= pwdata[`CTL_WIDTH-1:0];
            if (wr_irq)
            begin
                rollover_irq_enable_q   <= pwdata[`IRQ_ENABLE];
                peripheral_irq_enable_q <= pwdata[`IRQ_PERIPH];
                global_irq_enable_q     <= pwdata[`IRQ_GLOBAL];
            end
            // A hardware set in the clearing cycle wins.
            if (roll)
                rollover_flag_q <= 1'b1; // [R19]
            else if (wr_irq)
                rollover_flag_q <= pwdata[`IRQ_FLAG]; // [R20]
            if (compare_event)
                compare_flag_q <= 1'b1;
            else if (wr_irq)
                compare_flag_q <= pwdata[`IRQ_CMP_FLAG];
        end
    end

    assign rollover_irq = rollover_flag_q & rollover_irq_enable_q
                          & peripheral_irq_enable_q
                          & global_irq_enable_q; // [R20]

    // ======================================================================
    // Sleep wake-up
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            wake_req <= 1'b0;
        else
            wake_req <= sleep_mode & roll & timer_on & ext_src & sync_bypass
                        & rollover_irq_enable_q
                        & peripheral_irq_enable_q; // [R21]
    end

    // ======================================================================
    // Capture and compare time base
    assign timebase_valid = ~(ext_src & sync_bypass)
                            & ~(~ext_src & fast_internal_select); // [R14]
    assign cap_rise = pins_s[4] & ~cap_prev_q;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cc_q          <= `COUNT_ZERO;
            cap_prev_q    <= 1'b0;
            compare_event <= 1'b0;
        end
        else
        begin
            cap_prev_q <= pins_s[4];
            if (ctrl_q[`CTL_CAPTURE] && timebase_valid && cap_rise)
                cc_q <= count_q; // [R22]
            else if (wr_en && paddr == `OFS_CC_LOW)
                cc_q <= {cc_q[15:8], pwdata[7:0]};
            else if (wr_en && paddr == `OFS_CC_HIGH)
                cc_q <= {pwdata[7:0], cc_q[7:0]};
            // Fires once on the cycle the counter arrives at the match.
            compare_event <= ctrl_q[`CTL_COMPARE] & timebase_valid
                             & inc & (cc_q == count_d); // [R23]
        end
    end

    // ======================================================================
    // Read data and error response
    // Reads come from the clocked counter, so a byte is never torn. [R15]
    always @*
    begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == `OFS_CONTROL)
            prdata[`CTL_WIDTH-1:0] = ctrl_q;
        else if (paddr == `OFS_COUNT_LOW)
            prdata[7:0] = count_q[7:0]; // [R1]
        else if (paddr == `OFS_COUNT_HIGH)
            prdata[7:0] = count_q[15:8]; // [R1]
        else if (paddr == `OFS_IRQ)
        begin
            prdata[`IRQ_FLAG]     = rollover_flag_q;
            prdata[`IRQ_ENABLE]   = rollover_irq_enable_q;
            prdata[`IRQ_PERIPH]   = peripheral_irq_enable_q;
            prdata[`IRQ_GLOBAL]   = global_irq_enable_q;
            prdata[`IRQ_CMP_FLAG] = compare_flag_q;
        end
        else if (paddr == `OFS_CC_LOW)
            prdata[7:0] = cc_q[7:0];
        else if (paddr == `OFS_CC_HIGH)
            prdata[7:0] = cc_q[15:8];
        else if (paddr == `OFS_STATUS)
        begin
            prdata[`ST_DIR4]     = dir_bit_4;
            prdata[`ST_DIR5]     = dir_bit_5;
            prdata[`ST_PORT4]    = port_bit_4;
            prdata[`ST_PORT5]    = port_bit_5;
            prdata[`ST_TIMEBASE] = timebase_valid;
            prdata[`ST_ARMED]    = armed_q;
        end
        else
            pslverr = psel & penable;
        if (!rd_en)
            prdata = 32'h0000_0000;
    end

endmodule // gated_sixteen_bit_timer

/* File: test/gated_timer_checker_asserts.sv */
// Concurrent checks on the ports of the gated timer.
`timescale 1ns/1ps
`include "gated_timer_consts.vh"
module gated_timer_checker (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        sleep_mode,
    input wire logic        lp_osc_run,
    input wire logic        dir_bit_4,
    input wire logic        dir_bit_5,
    input wire logic        port_bit_4,
    input wire logic        port_bit_5,
    input wire logic        rollover_irq,
    input wire logic        wake_req,
    input wire logic        compare_event,
    input wire logic        timebase_valid
);
    logic [11:0] ctl_q;
    logic  [3:1] en_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Shadow copies of the control and enable bits.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl_q <= 12'h000;
            en_q  <= 3'h0;
        end
        else if (psel && penable && pwrite && paddr == `OFS_CONTROL)
            ctl_q <= pwdata[11:0];
        else if (psel && penable && pwrite && paddr == `OFS_IRQ)
            en_q <= pwdata[3:1];
    end

    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    // ==========================================================
    // Assertions.
    a_osc_follows: assert property (s_wr(`OFS_CONTROL) |=>
        lp_osc_run == $past(pwdata[`CTL_LP_OSC_EN]))
        else $error("oscillator run does not follow its enable");
    a_dir_forced: assert property (lp_osc_run |->
        dir_bit_4 && dir_bit_5)
        else $error("direction bits not forced high");
    a_port_forced: assert property (lp_osc_run |->
        !port_bit_4 && !port_bit_5)
        else $error("port bits not forced low");
    a_no_timebase: assert property ((ctl_q[1] && ctl_q[2])
        || (!ctl_q[1] && ctl_q[8]) |-> !timebase_valid)
        else $error("time base valid in a forbidden mode");
    a_irq_enables: assert property (rollover_irq |-> &en_q)
        else $error("interrupt without all three enables");
    a_irq_holds: assert property ($fell(rollover_irq) |->
        $past(psel && penable && pwrite && paddr == `OFS_IRQ))
        else $error("interrupt dropped without a software write");
    a_wake_cond: assert property (wake_req |-> ctl_q[0] && ctl_q[1]
        && ctl_q[2] && en_q[1] && en_q[2] && $past(sleep_mode))
        else $error("wake request outside its conditions");
    a_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    a_cmp_pulse: assert property (compare_event |=> !compare_event)
        else $error("compare event longer than one cycle");
    a_count_width: assert property (psel && penable && !pwrite
        && (paddr == `OFS_COUNT_LOW || paddr == `OFS_COUNT_HIGH)
        |-> prdata[31:8] == 24'h00_0000)
        else $error("count byte read carries extra bits");
endmodule // gated_timer_checker

bind gated_sixteen_bit_timer gated_timer_checker u_chk (
    .ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .sleep_mode, .lp_osc_run, .dir_bit_4, .dir_bit_5, .port_bit_4,
    .port_bit_5, .rollover_irq, .wake_req, .compare_event, .timebase_valid
);

/* File: test/pin_partner.sv */
// Far-side pins: external count clock, crystal clock and gate sources.
`timescale 1ns/1ps
module pin_partner #(
    parameter int HALF_NS = 337
) (
    input  wire logic use_lp,
    input  wire logic gate_lvl,
    input  wire logic gate_sel,
    output logic      ext_count_input,
    output logic      lp_osc_clk,
    output wire logic gate_pin,
    output wire logic comparator_two_out
);
    // The selected gate source carries the level, the other its inverse.
    assign gate_pin           = gate_sel ? ~gate_lvl : gate_lvl;
    assign comparator_two_out = gate_sel ? gate_lvl : ~gate_lvl;

    initial
    begin
        ext_count_input = 1'b0;
        lp_osc_clk      = 1'b0;
    end

    // Sends n rising edges on the chosen clock pin, then stays low.
    task automatic pulses(input int n);
        repeat (n)
        begin
            #(HALF_NS);
            if (use_lp)
                lp_osc_clk = 1'b1;
            else
                ext_count_input = 1'b1;
            #(HALF_NS);
            lp_osc_clk      = 1'b0;
            ext_count_input = 1'b0;
        end
        #(HALF_NS);
    endtask
endmodule // pin_partner

/* File: test/gated_sixteen_bit_timer_tb_top.sv */
// Self-checking bench for the gated sixteen bit timer.
`timescale 1ns/1ps
`include "gated_timer_consts.vh"
module gated_sixteen_bit_timer_tb_top;
    logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ext_count_input, lp_osc_clk, gate_pin, comparator_two_out;
    logic        capture_event, sleep_mode, osc_use_allowed, err;
    logic  [3:0] pins;
    logic        lp_osc_run, dir_bit_4, dir_bit_5, port_bit_4, port_bit_5;
    logic        rollover_irq, wake_req, compare_event, timebase_valid;
    logic        use_lp, gate_lvl, gate_sel;
    int          n_errors, n_tests, n_wake, n_cmp, n, k;

    gated_sixteen_bit_timer dut (
        .ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_count_input, .lp_osc_clk,
        .gate_pin, .comparator_two_out, .capture_event, .sleep_mode,
        .osc_use_allowed, .dir_bit_4_in(pins[0]), .dir_bit_5_in(pins[1]),
        .port_bit_4_in(pins[2]), .port_bit_5_in(pins[3]), .lp_osc_run,
        .dir_bit_4, .dir_bit_5, .port_bit_4, .port_bit_5, .rollover_irq,
        .wake_req, .compare_event, .timebase_valid
    );
    pin_partner far (
        .use_lp, .gate_lvl, .gate_sel, .ext_count_input, .lp_osc_clk,
        .gate_pin, .comparator_two_out
    );

    // ==========================================================
    // Clock, pulse monitors and bus tasks.
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        n_wake = n_wake + (wake_req === 1'b1);
        n_cmp  = n_cmp + (compare_event === 1'b1);
    end

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_val(rd, exp);
    endtask
    task report_and_stop;
        $display("errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #(60_000 * 100);
        n_errors++;
        report_and_stop;
    end

    // ==========================================================
    // Main sequence.
    initial
    begin
        {nrst, psel, penable, pwrite, capture_event, sleep_mode} = '0;
        {osc_use_allowed, use_lp, gate_lvl, gate_sel} = '0;
        {paddr, pwdata, pins} = '0;
        {n_errors, n_tests, n_wake, n_cmp} = '0;
        k = $urandom(32'hac5f);
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rdchk(`OFS_CONTROL, 32'h0000_0000);
        rdchk(`OFS_COUNT_HIGH, 32'h0000_0000);
        n = $urandom;
        wr(`OFS_COUNT_LOW, n);
        wr(`OFS_COUNT_HIGH, ~n);
        wr(12'h01C, 32'h0000_0000);
        chk_val(err, 1'b1);
        rdchk(`OFS_COUNT_LOW, n & 32'h0000_00FF);
        rdchk(`OFS_COUNT_HIGH, ~n & 32'h0000_00FF);
        for (int m = 0; m < 8; m++)
        begin
            n = 9 + $urandom % 31;
            wr(`OFS_CONTROL, 32'h0000_0000);
            wr(`OFS_COUNT_LOW, 32'h0000_0000);
            wr(`OFS_COUNT_HIGH, 32'h0000_0000);
            wr(`OFS_CONTROL, 3 | (m & 1) << 2 | (m >> 1) << 4 | (m & 2) << 7);
            far.pulses(n);
            wr(`OFS_CONTROL, 32'h0000_0000);
            rdchk(`OFS_COUNT_LOW,
                  (n - 1) >> (m >> 1));
        end
        for (int m = 0; m < 9; m++)
        begin
            gate_sel <= m[0];
            gate_lvl <= m[1];
            wr(`OFS_COUNT_LOW, 32'h0000_0000);
            wr(`OFS_CONTROL, (m < 8) | 32'h0000_0042 | (m & 4) << 5
               | (m & 1) << 9);
            far.pulses(9);
            wr(`OFS_CONTROL, 32'h0000_0000);
            rdchk(`OFS_COUNT_LOW,
                  (m < 8 && m[1] == m[2]) ? 8 : 0);
        end
        for (int f = 0; f < 2; f++)
        begin
            wr(`OFS_COUNT_LOW, 32'h0000_00F0);
            wr(`OFS_COUNT_HIGH, 32'h0000_00FF);
            wr(`OFS_CONTROL, 1 | f << 8);
            repeat (30) @(posedge ref_clk);
            wr(`OFS_CONTROL, 32'h0000_0000);
            rdchk(`OFS_COUNT_HIGH, f ? 0 : 32'h0000_00FF);
            rdchk(`OFS_IRQ, f);
            wr(`OFS_IRQ, 32'h0000_0000);
        end
        pins <= $urandom;
        wr(`OFS_CONTROL, 32'h0000_000A);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk_val(rd & 32'h0000_000F, 32'h0000_0003);
        repeat (20) @(posedge ref_clk);
        use_lp <= 1'b1;
        for (int a = 0; a < 2; a++)
        begin
            osc_use_allowed <= a[0];
            wr(`OFS_COUNT_LOW, 32'h0000_0000);
            wr(`OFS_CONTROL, 32'h0000_000B);
            far.pulses(9);
            wr(`OFS_CONTROL, 32'h0000_0008);
            rdchk(`OFS_COUNT_LOW, a ? 8 : 0);
        end
        use_lp <= 1'b0;
        wr(`OFS_CONTROL, 32'h0000_0000);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk_val(rd & 32'h0000_000F, pins);
        wr(`OFS_IRQ, 32'h0000_0006);
        for (int a = 0; a < 2; a++)
        begin
            wr(`OFS_COUNT_LOW, 32'h0000_00F8);
            wr(`OFS_COUNT_HIGH, 32'h0000_00FF);
            wr(`OFS_CONTROL, 3 | a << 2);
            sleep_mode <= 1'b1;
            n_wake = 0;
            far.pulses(12);
            sleep_mode <= 1'b0;
            wr(`OFS_CONTROL, 32'h0000_0000);
            rdchk(`OFS_COUNT_HIGH, a ? 0 : 32'h0000_00FF);
            chk_val(n_wake, a);
            chk_val(rollover_irq, 1'b0);
            wr(`OFS_IRQ, 32'h0000_000E | a);
            chk_val(rollover_irq, a);
            wr(`OFS_IRQ, 32'h0000_0006);
        end
        wr(`OFS_COUNT_LOW, 32'h0000_0000);
        wr(`OFS_COUNT_HIGH, 32'h0000_0000);
        wr(`OFS_CC_LOW, 32'h0000_0005);
        wr(`OFS_CC_HIGH, 32'h0000_0000);
        wr(`OFS_CONTROL, 32'h0000_0803);
        n_cmp = 0;
        far.pulses(9);
        chk_val(n_cmp, 1);
        wr(`OFS_CONTROL, 32'h0000_0403);
        capture_event <= 1'b1;
        repeat (5) @(posedge ref_clk);
        capture_event <= 1'b0;
        rdchk(`OFS_CC_LOW, 32'h0000_0008);
        report_and_stop;
    end
endmodule // gated_sixteen_bit_timer_tb_top
